/* File: logic/tla_consts.svh */
// Offsets, field positions, reset values and timing counts of the alert logic
`ifndef TLA_CONSTS_SVH
`define TLA_CONSTS_SVH
`define TLA_OFF_CONFIG       12'h000
`define TLA_OFF_MODE         12'h004
`define TLA_OFF_CONV_RATE    12'h008
`define TLA_OFF_STATUS       12'h00C
`define TLA_OFF_LOCAL_RD     12'h010
`define TLA_OFF_REMOTE_RD    12'h014
`define TLA_OFF_LOCAL_HIGH   12'h018
`define TLA_OFF_REMOTE_HIGH  12'h01C
`define TLA_OFF_REMOTE_LOW   12'h020
`define TLA_OFF_REMOTE_CRIT  12'h024
`define TLA_OFF_HYST         12'h028
`define TLA_OFF_OFFSET       12'h02C
`define TLA_OFF_ONE_SHOT     12'h030
`define TLA_CFG_MASK         7
`define TLA_CFG_STANDBY      6
`define TLA_CFG_PWM_STBY_DIS 5
`define TLA_CFG_TACH_SEL     2
`define TLA_CFG_FAULT_Q      0
`define TLA_MODE_COMPARATOR  0
`define TLA_MODE_ALERT_CFG   1
`define TLA_ST_BUSY          7
`define TLA_ST_OPEN          4
`define TLA_RST_CONFIG       8'h00
`define TLA_RST_MODE         8'h00
`define TLA_RST_CONV_RATE    8'h00
`define TLA_RST_LOCAL_HIGH   8'h46
`define TLA_RST_REMOTE_HIGH  11'h0230
`define TLA_RST_REMOTE_LOW   11'h0000
`define TLA_RST_REMOTE_CRIT  8'h55
`define TLA_RST_HYST         8'h04
`define TLA_FAULT_Q_DEPTH    2'h3
`define TLA_ARA_ADDR         7'h0C
`define TLA_OWN_ADDR         7'h4C
`define TLA_CONV_TIME_US     31250
`define TLA_CLK_MHZ          250
`endif

/* File: logic/tla_pkg.sv */
// Types shared by the alert logic
package tla_pkg;
  typedef enum logic [2:0] {
    TLA_CV_CONV = 3'b001,
    TLA_CV_IDLE = 3'b010,
    TLA_CV_STBY = 3'b100
  } tla_conv_t;
  typedef enum logic [4:0] {
    TLA_SM_IDLE = 5'b00001,
    TLA_SM_ADDR = 5'b00010,
    TLA_SM_ACK  = 5'b00100,
    TLA_SM_SEND = 5'b01000,
    TLA_SM_MACK = 5'b10000
  } tla_smb_t;
  typedef logic [10:0] tla_remote_t;
endpackage

/* File: logic/tla_alert.sv */
// Conversion timing, limit checks, status flags, alert pin and alert-response logic
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "tla_consts.svh"
module tla_alert #(
  parameter int CONV_CYCLES = (`TLA_CONV_TIME_US * `TLA_CLK_MHZ) // Cycles per conversion
) (
  input  wire logic                 pclk,            // APB clock, 250 MHz
  input  wire logic                 presetn,         // Async reset, active low
  input  wire logic                 psel,            // APB select
  input  wire logic                 penable,         // APB enable
  input  wire logic                 pwrite,          // APB direction
  input  wire logic [11:0]          paddr,           // APB byte address
  input  wire logic [31:0]          pwdata,          // APB write data
  output logic      [31:0]          prdata,          // APB read data
  output logic                      pready,          // APB ready
  output logic                      pslverr,         // APB error on unmapped address
  input  wire logic [7:0]           adc_local,       // Local conversion result, 1 C
  input  wire tla_pkg::tla_remote_t adc_remote,      // Remote result, 0.125 C
  input  wire logic                 diode_open,      // Remote diode open fault
  input  wire logic                 smb_clk,         // Bus clock pin
  input  wire logic                 smb_dat_i,       // Bus data pin level
  output logic                      smb_dat_o,       // Bus data drive value
  output logic                      smb_dat_oe,      // Bus data pulled low when high
  output logic                      alert_o,         // Alert drive value
  output logic                      alert_oe,        // Alert pulled low when high
  output logic                      tach_mode,       // Shared pin used as tach input
  output logic                      pwm_stop         // Fan PWM must halt
);
  import tla_pkg::*;

  // Register file
  logic [7:0]  config_reg, mode_reg, conv_rate, local_high, remote_crit, hysteresis_value;
  tla_remote_t remote_high, remote_low, remote_offset;
  logic [7:0]  local_reading, status;
  tla_remote_t remote_reading;
  logic [31:0] rd_mux;
  logic        err_q;

  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire wr_en    = access & pwrite;
  wire rd_stat  = access & ~pwrite & (paddr == `TLA_OFF_STATUS);
  wire wr_cfg   = wr_en & (paddr == `TLA_OFF_CONFIG);
  wire wr_shot  = wr_en & (paddr == `TLA_OFF_ONE_SHOT);
  wire mask     = config_reg[`TLA_CFG_MASK];
  wire standby  = config_reg[`TLA_CFG_STANDBY];
  wire fault_q  = config_reg[`TLA_CFG_FAULT_Q];
  wire cmp_mode = mode_reg[`TLA_MODE_COMPARATOR];
  wire alert_cfg = mode_reg[`TLA_MODE_ALERT_CFG];
  wire mapped   = (paddr[1:0] == 2'b00) && (paddr <= `TLA_OFF_ONE_SHOT);

  always_comb begin
    unique case (paddr)
      `TLA_OFF_CONFIG:      rd_mux = {24'h00_0000, config_reg};
      `TLA_OFF_MODE:        rd_mux = {24'h00_0000, mode_reg};
      `TLA_OFF_CONV_RATE:   rd_mux = {24'h00_0000, conv_rate};
      `TLA_OFF_STATUS:      rd_mux = {24'h00_0000, status};
      `TLA_OFF_LOCAL_RD:    rd_mux = {24'h00_0000, local_reading};
      `TLA_OFF_REMOTE_RD:   rd_mux = {16'h0000, remote_reading, 5'h00};
      `TLA_OFF_LOCAL_HIGH:  rd_mux = {24'h00_0000, local_high};
      `TLA_OFF_REMOTE_HIGH: rd_mux = {16'h0000, remote_high, 5'h00};
      `TLA_OFF_REMOTE_LOW:  rd_mux = {16'h0000, remote_low, 5'h00};
      `TLA_OFF_REMOTE_CRIT: rd_mux = {24'h00_0000, remote_crit};
      `TLA_OFF_HYST:        rd_mux = {24'h00_0000, hysteresis_value};
      `TLA_OFF_OFFSET:      rd_mux = {16'h0000, remote_offset, 5'h00};
      default:              rd_mux = 32'h0000_0000; // One-shot reads zero
    endcase
  end

  // Data captured in the setup cycle so the access phase needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      err_q  <= 1'b0;
    end else if (setup) begin
      prdata <= rd_mux;
      err_q  <= ~mapped;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = access & err_q;

  // Conversion sequencer
  tla_conv_t   cv_state;
  logic [31:0] cv_cnt;
  logic [7:0]  idle_left;
  logic        conv_done;
  wire         cnt_end = (cv_cnt == 32'(CONV_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cv_state  <= TLA_CV_CONV;
      cv_cnt    <= 32'h0000_0000;
      idle_left <= 8'h00;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      unique case (cv_state)
        TLA_CV_CONV: begin
          cv_cnt <= cnt_end ? 32'h0000_0000 : cv_cnt + 32'h0000_0001;
          if (cnt_end) begin
            conv_done <= 1'b1;
            idle_left <= conv_rate;
            if (standby)
              cv_state <= TLA_CV_STBY;
            else if (conv_rate != 8'h00)
              cv_state <= TLA_CV_IDLE;
          end
        end
        TLA_CV_IDLE: begin
          // Idle is whole conversion periods, the conversion itself is untouched
          cv_cnt <= cnt_end ? 32'h0000_0000 : cv_cnt + 32'h0000_0001;
          if (standby) begin
            cv_state <= TLA_CV_STBY;
            cv_cnt   <= 32'h0000_0000;
          end else if (cnt_end) begin
            idle_left <= idle_left - 8'h01;
            if (idle_left == 8'h01)
              cv_state <= TLA_CV_CONV;
          end
        end
        TLA_CV_STBY: begin
          if (wr_shot || !standby)
            cv_state <= TLA_CV_CONV;
        end
        default: cv_state <= TLA_CV_CONV;
      endcase
    end
  end
  assign pwm_stop = standby & config_reg[`TLA_CFG_PWM_STBY_DIS];

  // Offset-corrected remote value and limit checks
  wire tla_remote_t remote_corr = adc_remote + remote_offset;
  wire signed [12:0] hyst_fine  = 13'(signed'({1'b0, hysteresis_value, 3'b000}));
  wire signed [9:0]  hyst_deg   = 10'(signed'({1'b0, hysteresis_value}));
  wire signed [9:0]  loc_s      = 10'(signed'(local_reading));
  wire signed [9:0]  rint_s     = 10'(signed'(remote_reading[10:3]));
  wire signed [12:0] rem_s      = 13'(signed'(remote_reading));
  logic [3:0] over, clear_ok;
  // Bits: 0 local high, 1 remote high, 2 remote low, 3 remote critical
  assign over[0] = $signed(local_reading) > $signed(local_high);
  assign over[1] = $signed(remote_reading) > $signed(remote_high);
  assign over[2] = $signed(remote_reading) < $signed(remote_low);
  assign over[3] = $signed(remote_reading[10:3]) > $signed(remote_crit);
  // Release band keeps the comparator output from chattering at the limit
  assign clear_ok[0] = loc_s <= 10'(signed'(local_high)) - hyst_deg;
  assign clear_ok[1] = rem_s <= 13'(signed'(remote_high)) - hyst_fine;
  assign clear_ok[2] = rem_s >= 13'(signed'(remote_low)) + hyst_fine;
  assign clear_ok[3] = rint_s <= 10'(signed'(remote_crit)) - hyst_deg;

  // Readings land one cycle after conversion end; checks run the cycle after
  logic eval;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_reading  <= 8'h00;
      remote_reading <= 11'h000;
      eval           <= 1'b0;
    end else begin
      eval <= conv_done;
      if (conv_done) begin
        local_reading  <= adc_local;
        remote_reading <= remote_corr;
      end
    end
  end

  logic [3:0] trip, cmp_act;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      logic [1:0] fq_cnt;
      wire  [1:0] fq_next = (fq_cnt == `TLA_FAULT_Q_DEPTH) ? fq_cnt : fq_cnt + 2'h1;
      assign trip[gi] = eval & over[gi] & (~fault_q | (fq_next == `TLA_FAULT_Q_DEPTH));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fq_cnt      <= 2'h0;
          cmp_act[gi] <= 1'b0;
        end else if (eval) begin
          fq_cnt <= over[gi] ? fq_next : 2'h0;
          if (trip[gi])
            cmp_act[gi] <= 1'b1;
          else if (clear_ok[gi])
            cmp_act[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Alert drive and response-address handshake
  logic ara_done;
  wire  int_any   = |status[3:0];
  wire  alert_req = ~mask & (cmp_mode ? |cmp_act : int_any);

  // Status: set wins over read-clear, busy and open live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status[3:0] <= 4'h0;
      status[6:5] <= 2'b00;
    end else if (rd_stat) begin
      status[3:0] <= trip;
    end else begin
      status[3:0] <= status[3:0] | trip;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status[`TLA_ST_BUSY] <= 1'b0;
      status[`TLA_ST_OPEN] <= 1'b0;
    end else begin
      status[`TLA_ST_BUSY] <= (cv_state == TLA_CV_CONV);
      status[`TLA_ST_OPEN] <= diode_open;
    end
  end

  // Configuration: hardware mask set beats a same-cycle software clear
  wire hw_mask = (rd_stat & ~cmp_mode & int_any) | ara_done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg       <= `TLA_RST_CONFIG;
      mode_reg         <= `TLA_RST_MODE;
      conv_rate        <= `TLA_RST_CONV_RATE;
      local_high       <= `TLA_RST_LOCAL_HIGH;
      remote_high      <= `TLA_RST_REMOTE_HIGH;
      remote_low       <= `TLA_RST_REMOTE_LOW;
      remote_crit      <= `TLA_RST_REMOTE_CRIT;
      hysteresis_value <= `TLA_RST_HYST;
      remote_offset    <= 11'h000;
    end else begin
      if (wr_cfg)
        config_reg <= pwdata[7:0];
      if (hw_mask)
        config_reg[`TLA_CFG_MASK] <= 1'b1;
      if (wr_en) begin
        unique case (paddr)
          `TLA_OFF_MODE:        mode_reg <= pwdata[7:0];
          `TLA_OFF_CONV_RATE:   conv_rate <= pwdata[7:0];
          `TLA_OFF_LOCAL_HIGH:  local_high <= pwdata[7:0];
          `TLA_OFF_REMOTE_HIGH: remote_high <= pwdata[15:5];
          `TLA_OFF_REMOTE_LOW:  remote_low <= pwdata[15:5];
          `TLA_OFF_REMOTE_CRIT: remote_crit <= pwdata[7:0];
          `TLA_OFF_HYST:        hysteresis_value <= pwdata[7:0];
          `TLA_OFF_OFFSET:      remote_offset <= pwdata[15:5];
          default:              ;
        endcase
      end
    end
  end

  assign tach_mode = config_reg[`TLA_CFG_TACH_SEL];
  assign alert_o   = 1'b0;
  assign alert_oe  = alert_req & ~tach_mode;

  // Bus pin sampling: three flops, a change counts when the last two agree
  logic [2:0] clk_sy, dat_sy;
  logic       scl, sda, scl_d, sda_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sy <= 3'b111;
      dat_sy <= 3'b111;
      scl    <= 1'b1;
      sda    <= 1'b1;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      clk_sy <= {clk_sy[1:0], smb_clk};
      dat_sy <= {dat_sy[1:0], smb_dat_i};
      if (clk_sy[1] == clk_sy[2])
        scl <= clk_sy[2];
      if (dat_sy[1] == dat_sy[2])
        sda <= dat_sy[2];
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c  = scl & scl_d & sda_d & ~sda;
  wire stop_c   = scl & scl_d & ~sda_d & sda;

  tla_smb_t   sm;
  logic [7:0] shreg;
  logic [3:0] bitn;
  localparam logic [6:0] OWN_ADDR = `TLA_OWN_ADDR;
  wire ara_hit = (shreg == {`TLA_ARA_ADDR, 1'b1}) & alert_oe & ~alert_cfg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sm         <= TLA_SM_IDLE;
      shreg      <= 8'h00;
      bitn       <= 4'h0;
      smb_dat_oe <= 1'b0;
      ara_done   <= 1'b0;
    end else begin
      ara_done <= 1'b0;
      if (start_c) begin
        sm         <= TLA_SM_ADDR;
        bitn       <= 4'h0;
        smb_dat_oe <= 1'b0;
      end else if (stop_c) begin
        sm         <= TLA_SM_IDLE;
        smb_dat_oe <= 1'b0;
      end else begin
        unique case (sm)
          TLA_SM_IDLE: smb_dat_oe <= 1'b0;
          TLA_SM_ADDR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda};
              bitn  <= bitn + 4'h1;
            end else if (scl_fall && bitn == 4'h8) begin
              sm         <= ara_hit ? TLA_SM_ACK : TLA_SM_IDLE;
              smb_dat_oe <= ara_hit;
            end
          end
          TLA_SM_ACK: begin
            if (scl_fall) begin
              sm         <= TLA_SM_SEND;
              shreg      <= {`TLA_OWN_ADDR, 1'b0};
              bitn       <= 4'h0;
              smb_dat_oe <= ~OWN_ADDR[6];
            end
          end
          TLA_SM_SEND: begin
            if (scl_rise && sda != shreg[7]) begin
              sm         <= TLA_SM_IDLE; // Lost arbitration, another device wins
              smb_dat_oe <= 1'b0;
            end else if (scl_rise) begin
              bitn <= bitn + 4'h1;
            end else if (scl_fall) begin
              shreg      <= {shreg[6:0], 1'b0};
              smb_dat_oe <= (bitn != 4'h8) & ~shreg[6];
              if (bitn == 4'h8)
                sm <= TLA_SM_MACK;
            end
          end
          TLA_SM_MACK: begin
            if (scl_rise) begin
              ara_done <= 1'b1; // Whole address went out intact
              sm       <= TLA_SM_IDLE;
            end
          end
          default: sm <= TLA_SM_IDLE;
        endcase
      end
    end
  end
  assign smb_dat_o = 1'b0;
endmodule

/* File: sim/tla_alert_asserts.sv */
// Concurrent checks on the alert logic ports, bound to the design top
`timescale 1ns/1ps
module tla_alert_asserts (
  input wire logic        pclk,       // Clock
  input wire logic        presetn,    // Reset, active low
  input wire logic        psel,       // APB select
  input wire logic        penable,    // APB enable
  input wire logic        pwrite,     // APB direction
  input wire logic [11:0] paddr,      // APB address
  input wire logic [31:0] pwdata,     // APB write data
  input wire logic [31:0] prdata,     // APB read data
  input wire logic        pready,     // APB ready
  input wire logic        pslverr,    // APB error
  input wire logic        smb_dat_oe, // Data pulled low
  input wire logic        alert_oe,   // Alert pulled low
  input wire logic        tach_mode,  // Pin used as tach
  input wire logic        pwm_stop    // Fan PWM halted
);
  logic stby, pwm_dis, tach_sh, cmp_mode, ara_ign, masked;
  wire acc     = psel && penable;
  wire cfg_wr  = acc && pwrite && paddr == 12'h000;
  wire mode_wr = acc && pwrite && paddr == 12'h004;
  wire st_rd   = acc && !pwrite && paddr == 12'h00C;

  // Shadow of the software-written bits; masked only tracks sets the checker can see
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {stby, pwm_dis, tach_sh, cmp_mode, ara_ign, masked} <= 6'h00;
    end else begin
      if (cfg_wr) {stby, pwm_dis, tach_sh} <= {pwdata[6], pwdata[5], pwdata[2]};
      if (mode_wr) {ara_ign, cmp_mode} <= pwdata[1:0];
      if (cfg_wr) masked <= pwdata[7];
      else if (st_rd && !cmp_mode && alert_oe) masked <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_status_read;
    psel && penable && !pwrite && paddr == 12'h00C;
  endsequence

  a_reset_quiet: assert property ($rose(presetn) |-> !alert_oe && !smb_dat_oe && !tach_mode && !pwm_stop)
    else $error("outputs active right after reset");
  a_read_release: assert property (s_status_read ##0 (!cmp_mode && alert_oe) |=> !alert_oe)
    else $error("alert still low after status read");
  a_mask_holds: assert property (masked |-> !alert_oe)
    else $error("alert low while masked");
  a_tach_blocks: assert property ((tach_mode == tach_sh) and (tach_mode |-> !alert_oe))
    else $error("tach select and alert output disagree");
  a_pwm_standby: assert property (pwm_stop == (stby && pwm_dis))
    else $error("pwm stop does not follow standby bits");
  a_ara_ignored: assert property (ara_ign |-> !smb_dat_oe)
    else $error("data driven with response address ignored");
  a_ack_alerting: assert property ($rose(smb_dat_oe) |-> alert_oe)
    else $error("data driven by a device that is not alerting");
  a_oneshot_zero: assert property (acc && !pwrite && paddr == 12'h030 |-> prdata == 32'h0000_0000)
    else $error("one-shot read not zero");
  a_no_wait: assert property (acc |-> pready && (pslverr == !(paddr <= 12'h030 && paddr[1:0] == 2'h0)))
    else $error("wait state or error on a mapped register");
endmodule

bind tla_alert tla_alert_asserts tla_alert_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .smb_dat_oe(smb_dat_oe), .alert_oe(alert_oe), .tach_mode(tach_mode), .pwm_stop(pwm_stop)
);

/* File: sim/tla_smb_host.sv */
// Bus host model that polls the alert response address
`timescale 1ns/1ps
module tla_smb_host (
  input  wire logic pclk,    // Timing reference
  output logic      scl,     // Bus clock, idle high
  output logic      sda_low, // Pull data low
  input  wire logic sda      // Data line level
);
  localparam logic [7:0] ARA_RD = 8'h19;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // 32 ns bit; the device sees a clock fall five cycles late, so low lasts six and high two
  task automatic put(input logic b, output logic got);
    hold(2);
    sda_low <= !b;
    hold(4);
    scl <= 1'b1;
    hold(2);
    got = sda;
    scl <= 1'b0;
  endtask

  // Jam pulls data low in one reply bit to provoke a lost arbitration
  task automatic ara_poll(input int jam, output logic ack, output logic [7:0] addr);
    logic g;
    sda_low <= 1'b1;
    hold(4);
    scl <= 1'b0;
    for (int i = 7; i >= 0; i--) put(ARA_RD[i], g);
    put(1'b1, g);
    ack = !g;
    for (int i = 7; i >= 0; i--) begin
      put(jam != i, g);
      addr[i] = g;
    end
    put(1'b1, g);
    hold(2);
    sda_low <= 1'b1;
    hold(2);
    scl <= 1'b1;
    hold(4);
    sda_low <= 1'b0;
    hold(4);
  endtask
endmodule

/* File: sim/tla_alert_tb.sv */
// Self-checking bench for the limit and alert logic
`timescale 1ns/1ps
module tla_alert_tb;
  localparam logic [31:0] CFG = 32'h0000_0040; // Standby, so each conversion is a one-shot
  logic                 pclk, presetn, psel, penable, pwrite, diode_open, host_low, scl, ack;
  logic                 pready, pslverr, smb_dat_o, smb_dat_oe, alert_o, alert_oe, tach_mode, pwm_stop;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, r;
  logic [7:0]           adc_local, got;
  tla_pkg::tla_remote_t adc_remote;
  int                   n_fail = 0;
  int                   checks_done = 0;
  logic [7:0]           tl [5] = '{8'h50, 8'h20, 8'h20, 8'h46, 8'h20};
  logic [10:0]          tr [5] = '{11'h100, 11'h2F0, 11'h2A8, 11'h230, 11'h7F8};
  logic [4:0]           te [5] = '{5'h01, 5'h0A, 5'h02, 5'h00, 5'h14};
  logic [11:0]          ra [8] = '{12'h000, 12'h004, 12'h008, 12'h018, 12'h01C, 12'h024, 12'h028, 12'h030};
  logic [31:0]          rv [8] = '{32'h0, 32'h0, 32'h0, 32'h46, 32'h4600, 32'h55, 32'h4, 32'h0};
  wire                  smb_dat_i = !(smb_dat_oe || host_low);

  tla_alert #(.CONV_CYCLES(200)) tla_alert_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_local(adc_local), .adc_remote(adc_remote), .diode_open(diode_open),
    .smb_clk(scl), .smb_dat_i(smb_dat_i), .smb_dat_o(smb_dat_o), .smb_dat_oe(smb_dat_oe),
    .alert_o(alert_o), .alert_oe(alert_oe), .tach_mode(tach_mode), .pwm_stop(pwm_stop)
  );
  tla_smb_host tla_smb_host_i (.pclk(pclk), .scl(scl), .sda_low(host_low), .sda(smb_dat_i));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // One APB transfer; ends one idle cycle later so the next setup never overlaps
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    chk("slave_error", {31'h0, a > 12'h030}, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic conv1;
    apb(1'b1, 12'h030, 32'h0, r);
    tick(210);
  endtask

  task automatic results;
    $display("Totals: %0d checks, %0d failures", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    tick(20000);
    n_fail++;
    results();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, diode_open} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    adc_local = 8'h20;
    adc_remote = 11'h100;
    tick(12);
    presetn <= 1'b1;
    tick(1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ra[i], 32'h0, r);
      chk("reset_value", rv[i], r);
    end
    apb(1'b0, 12'h040, 32'h0, r);
    chk("unmapped_read", 32'h0, r);
    $display("test reset values done");
    apb(1'b1, 12'h000, CFG, r);
    tick(450);
    for (int i = 0; i < 5; i++) begin
      adc_local <= tl[i];
      adc_remote <= tr[i];
      diode_open <= (i == 4);
      conv1();
      apb(1'b0, 12'h00C, 32'h0, r);
      apb(1'b1, 12'h000, CFG, r);
      conv1();
      chk("alert_pin", {31'h0, |te[i][3:0]}, alert_oe);
      apb(1'b0, 12'h00C, 32'h0, r);
      chk("status", {27'h0, te[i]}, r & 32'h1F);
      chk("alert_released", 32'h0, alert_oe);
    end
    $display("test limit table done");
    diode_open <= 1'b0;
    adc_remote <= 11'h100;
    adc_local <= 8'h50;
    apb(1'b1, 12'h000, CFG, r);
    conv1();
    chk("alert_set", 32'h1, alert_oe);
    apb(1'b0, 12'h00C, 32'h0, r);
    chk("status_first", 32'h1, r & 32'h1F);
    chk("alert_self_mask", 32'h0, alert_oe);
    conv1();
    chk("alert_masked", 32'h0, alert_oe);
    apb(1'b1, 12'h000, CFG, r);
    chk("alert_unmasked", 32'h1, alert_oe);
    apb(1'b0, 12'h00C, 32'h0, r);
    chk("status_again", 32'h1, r & 32'h1F);
    $display("test interrupt mode done");
    apb(1'b1, 12'h000, CFG | 32'h1, r);
    adc_local <= 8'h20;
    conv1();
    apb(1'b0, 12'h00C, 32'h0, r);
    adc_local <= 8'h50;
    conv1();
    conv1();
    apb(1'b0, 12'h00C, 32'h0, r);
    chk("queue_two", 32'h0, r & 32'h1F);
    conv1();
    apb(1'b0, 12'h00C, 32'h0, r);
    chk("queue_three", 32'h1, r & 32'h1F);
    apb(1'b1, 12'h000, CFG, r);
    $display("test fault queue done");
    apb(1'b1, 12'h004, 32'h1, r);
    conv1();
    chk("cmp_trip", 32'h1, alert_oe);
    adc_local <= 8'h44;
    conv1();
    chk("cmp_in_band", 32'h1, alert_oe);
    adc_local <= 8'h42;
    conv1();
    chk("cmp_release", 32'h0, alert_oe);
    apb(1'b1, 12'h004, 32'h0, r);
    apb(1'b0, 12'h00C, 32'h0, r);
    apb(1'b1, 12'h000, CFG, r);
    $display("test comparator done");
    adc_local <= 8'h50;
    apb(1'b1, 12'h030, 32'h0, r);
    tick(190);
    chk("conv_not_yet", 32'h0, alert_oe);
    tick(20);
    chk("conv_done", 32'h1, alert_oe);
    apb(1'b1, 12'h004, 32'h2, r);
    tla_smb_host_i.ara_poll(-1, ack, got);
    chk("ara_ignored", 32'h0, ack);
    apb(1'b1, 12'h004, 32'h0, r);
    tla_smb_host_i.ara_poll(7, ack, got);
    chk("ara_lost_addr", 32'h7F, got);
    chk("ara_lost_alert", 32'h1, alert_oe);
    tla_smb_host_i.ara_poll(-1, ack, got);
    chk("ara_ack", 32'h1, ack);
    chk("ara_addr", 32'h98, got);
    chk("ara_release", 32'h0, alert_oe);
    $display("test alert response done");
    apb(1'b0, 12'h00C, 32'h0, r);
    apb(1'b1, 12'h000, CFG, r);
    tick(500);
    chk("standby_idle", 32'h0, alert_oe);
    apb(1'b1, 12'h000, CFG | 32'h20, r);
    chk("pwm_stopped", 32'h1, pwm_stop);
    apb(1'b1, 12'h000, 32'h20, r);
    chk("pwm_running", 32'h0, pwm_stop);
    apb(1'b1, 12'h000, 32'h4, r);
    apb(1'b1, 12'h02C, 32'h0000_FF00, r);
    adc_remote <= 11'h100;
    tick(450);
    chk("tach_select", 32'h1, tach_mode);
    chk("tach_no_alert", 32'h0, alert_oe);
    apb(1'b0, 12'h014, 32'h0, r);
    chk("remote_offset", 32'h0000_1F00, r);
    chk("pin_levels", 32'h0, {30'h0, alert_o, smb_dat_o});
    $display("test standby and offset done");
    apb(1'b1, 12'h008, 32'h1, r);
    do apb(1'b0, 12'h00C, 32'h0, r); while (r[7]);
    tick(180);
    apb(1'b0, 12'h00C, 32'h0, r);
    chk("idle_gap", 32'h0, {31'h0, r[7]});
    tick(20);
    apb(1'b0, 12'h00C, 32'h0, r);
    chk("conv_after_gap", 32'h1, {31'h0, r[7]});
    $display("test conversion rate done");
    results();
  end
endmodule
